// >>> hw/gpio3_pkg.sv
// constants for the three-port i/o block with parallel slave control
package gpio3_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0] GPIO_C_DATA_IDX      = 8'h07;
   localparam logic [7:0] GPIO_D_DATA_IDX      = 8'h08;
   localparam logic [7:0] GPIO_E_DATA_IDX      = 8'h09;
   localparam logic [7:0] GPIO_C_DIRECTION_IDX = 8'h87;
   localparam logic [7:0] GPIO_D_DIRECTION_IDX = 8'h88;
   localparam logic [7:0] GPIO_E_DIR_CTRL_IDX  = 8'h89;
   localparam int         IDX_LSB              = 2;
   localparam int         IDX_MSB              = 9;
   // reset values
   localparam logic [7:0] C_DIR_RST            = 8'hff;
   localparam logic [7:0] D_DIR_RST            = 8'hff;
   localparam logic [2:0] E_DIR_RST            = 3'h7;
   localparam logic [7:0] LATCH_RST            = 8'h00;
   // third direction register fields
   localparam int         IBF_BIT              = 7;
   localparam int         OBF_BIT              = 6;
   localparam int         INPUT_OVERFLOW_FLAG_BIT             = 5;
   localparam int         MODE_BIT             = 4;
   // third port pin positions
   localparam int         RD_PIN               = 0;
   localparam int         WR_PIN               = 1;
   localparam int         CS_PIN               = 2;
   // first port shared pin positions
   localparam int         C_CCP2_BIT           = 1;
   localparam int         C_CCP1_BIT           = 2;
   localparam int         C_SCK_BIT            = 3;
   localparam int         C_SDA_BIT            = 4;
   localparam int         C_SDO_BIT            = 5;
   localparam int         C_TX_BIT             = 6;
   localparam int         C_DT_BIT             = 7;
   // strobe release to flag set: second phase, then fourth phase
   localparam int         PSP_DONE_CYC         = 2;
   localparam logic [1:0] PSP_DONE_LAST        = 2'(PSP_DONE_CYC - 1);
   localparam int         PIN_W                = 19;
   localparam logic [1:0] HTRANS_NONSEQ_BIT    = 2'h2;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WR   = 4'h2,
      ST_RD   = 4'h4,
      ST_DONE = 4'h8
   } psp_state_t;
endpackage : gpio3_pkg

// >>> hw/three_port_io.sv
// three general purpose ports with an 8-bit parallel slave bus mode
//
// Notes on behaviour
// RQ1: first port is 8 bits, each pin's direction set by its own bit.
// RQ2: an enabled peripheral overrides a shared pin's direction bit.
// RQ3: software avoids read-modify-write on first direction register under override.
// RQ4: peripheral output enable acts only while that peripheral selects the pin.
// RQ5: first port bit 3 serial clock, bit 4 serial data in, bit 5 out.
// RQ6: with transceiver, bit 6 transmit/clock and bit 7 receive/data.
// RQ7: bit 2 carries capture/compare/pwm one; bit 1 the second unit.
// RQ8: second port is 8 bits, each pin's direction independently set.
// RQ9: slave mode bit turns second port into an 8-bit slave data bus.
// RQ10: third port has three pins with independent directions.
// RQ11: in slave mode the three pins are strobe inputs; software keeps them input.
// RQ12: bit 7 read-only input buffer full flag.
// RQ13: bit 6 read-only output buffer full flag.
// RQ14: bit 5 set on write before prior word read; software clears it.
// RQ15: low three direction bits steer read, write, select pins; 1 is input.
// RQ16: read strobe low with select low means external read.
// RQ17: write strobe low with select low means external write.
// RQ18: select pin low means selected.
// RQ19: unimplemented bits read zero.
// RQ20: direction bit 1 floats the pin, 0 drives the output latch.
// RQ21: data reads return pin levels, writes go to the output latch; in slave mode a second port read returns the input latch instead.
// RQ22: input full set two cycles after write ends; only processor read clears.
// RQ23: outside slave mode both full flags held clear, overflow left alone.
// RQ24: processor write sets output full, external read clears it.
`timescale 1ns/1ns
module three_port_io #(
   parameter bit HAS_CCP2  = 1'b1,          // second capture unit present
   parameter bit HAS_USART = 1'b1           // serial transceiver present
) (
   input  wire logic        i_ref_clk,      // core clock
   input  wire logic        i_sys_rst,      // sync reset, active high
   input  wire logic        i_hsel,         // ahb slave select
   input  wire logic [31:0] i_haddr,        // ahb address
   input  wire logic [1:0]  i_htrans,       // ahb transfer type
   input  wire logic        i_hwrite,       // ahb write
   input  wire logic [2:0]  i_hsize,        // ahb size, word only
   input  wire logic [31:0] i_hwdata,       // ahb write data
   input  wire logic        i_hready,       // ahb bus ready
   output logic      [31:0] o_hrdata,       // ahb read data
   output logic             o_hreadyout,    // ahb slave ready
   output logic             o_hresp,        // ahb response, always okay
   input  wire logic [7:0]  i_c_pin,        // first port pin levels
   output logic      [7:0]  o_c_out,        // first port drive value
   output logic      [7:0]  o_c_oe,         // first port drive enable
   output logic      [7:0]  o_c_level,      // filtered pins to peripherals
   input  wire logic [7:0]  i_d_pin,        // second port pin levels
   output logic      [7:0]  o_d_out,        // second port drive value
   output logic      [7:0]  o_d_oe,         // second port drive enable
   input  wire logic [2:0]  i_e_pin,        // third port pin levels
   output logic      [2:0]  o_e_out,        // third port drive value
   output logic      [2:0]  o_e_oe,         // third port drive enable
   input  wire logic        i_ccp1_sel,     // unit one owns its pin
   input  wire logic        i_ccp1_oe,      // unit one wants to drive
   input  wire logic        i_ccp1_out,     // unit one drive value
   input  wire logic        i_ccp2_sel,     // unit two owns its pin
   input  wire logic        i_ccp2_oe,      // unit two wants to drive
   input  wire logic        i_ccp2_out,     // unit two drive value
   input  wire logic        i_ssp_sel,      // serial port owns its pins
   input  wire logic        i_ssp_sck_oe,   // serial clock drive enable
   input  wire logic        i_ssp_sck_out,  // serial clock value
   input  wire logic        i_ssp_sda_oe,   // bidirectional data drive enable
   input  wire logic        i_ssp_sda_out,  // bidirectional data value
   input  wire logic        i_ssp_sdo_out,  // serial data out value
   input  wire logic        i_usart_sel,    // transceiver owns its pins
   input  wire logic        i_usart_tx_oe,  // transmit/clock drive enable
   input  wire logic        i_usart_tx_out, // transmit/clock value
   input  wire logic        i_usart_dt_oe,  // receive/data drive enable
   input  wire logic        i_usart_dt_out  // receive/data value
);
   import gpio3_pkg::*;

   function automatic logic [7:0] reg_index(input logic [31:0] addr);
      reg_index = addr[IDX_MSB:IDX_LSB];
   endfunction : reg_index

   // pin synchroniser: a change counts once stages two and three agree
   logic [PIN_W-1:0] s1_r, s2_r, s3_r, pins_r, pins_nxt;
   always_comb begin
      pins_nxt = (s2_r & s3_r) | (pins_r & (s2_r ^ s3_r));
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         pins_r <= '0;
      end else begin
         s1_r   <= {i_e_pin, i_d_pin, i_c_pin};
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         pins_r <= pins_nxt;
      end
   end

   logic [7:0] c_lvl, d_lvl;
   logic [2:0] e_lvl;
   logic       cs_n, wr_n, rd_n;
   assign c_lvl = pins_r[7:0];
   assign d_lvl = pins_r[15:8];
   assign e_lvl = pins_r[18:16];
   assign cs_n  = e_lvl[CS_PIN];
   assign wr_n  = e_lvl[WR_PIN];
   assign rd_n  = e_lvl[RD_PIN];

   // state
   logic [7:0]  c_lat_r, c_lat_nxt, d_lat_r, d_lat_nxt, c_dir_r, c_dir_nxt;
   logic [7:0]  d_dir_r, d_dir_nxt, in_lat_r, in_lat_nxt;
   logic [2:0]  e_lat_r, e_lat_nxt, e_dir_r, e_dir_nxt;
   logic        mode_r, mode_nxt, ibf_r, ibf_nxt, obf_r, obf_nxt;
   logic        input_overflow_flag_r, input_overflow_flag_nxt, wr_pend_r, wr_pend_nxt;
   logic [7:0]  wr_idx_r, wr_idx_nxt;
   logic [31:0] hrdata_nxt;
   logic [7:0]  c_out_nxt, c_oe_nxt, d_out_nxt, d_oe_nxt;
   logic [2:0]  e_out_nxt, e_oe_nxt;
   logic [1:0]  cnt_r, cnt_nxt;
   psp_state_t  st_r, st_nxt;

   logic        addr_ok, rd_req, wr_d, ext_wr_go, ext_rd_go, ext_wr_done;
   logic [7:0]  ridx;
   logic [7:0]  p_sel, p_oe, p_out;

   // shared pin routing of the first port
   always_comb begin
      p_sel = '0;
      p_oe  = '0;
      p_out = '0;
      p_sel[C_CCP1_BIT] = i_ccp1_sel;                                   // [RQ7]
      p_oe[C_CCP1_BIT]  = i_ccp1_oe;
      p_out[C_CCP1_BIT] = i_ccp1_out;
      p_sel[C_CCP2_BIT] = HAS_CCP2 & i_ccp2_sel;                        // [RQ7]
      p_oe[C_CCP2_BIT]  = i_ccp2_oe;
      p_out[C_CCP2_BIT] = i_ccp2_out;
      p_sel[C_SCK_BIT]  = i_ssp_sel;                                    // [RQ5]
      p_oe[C_SCK_BIT]   = i_ssp_sck_oe;
      p_out[C_SCK_BIT]  = i_ssp_sck_out;
      p_sel[C_SDA_BIT]  = i_ssp_sel;                                    // [RQ5]
      p_oe[C_SDA_BIT]   = i_ssp_sda_oe;
      p_out[C_SDA_BIT]  = i_ssp_sda_out;
      p_sel[C_SDO_BIT]  = i_ssp_sel;                                    // [RQ5]
      p_oe[C_SDO_BIT]   = 1'b1;
      p_out[C_SDO_BIT]  = i_ssp_sdo_out;
      p_sel[C_TX_BIT]   = HAS_USART & i_usart_sel;                      // [RQ6]
      p_oe[C_TX_BIT]    = i_usart_tx_oe;
      p_out[C_TX_BIT]   = i_usart_tx_out;
      p_sel[C_DT_BIT]   = HAS_USART & i_usart_sel;                      // [RQ6]
      p_oe[C_DT_BIT]    = i_usart_dt_oe;
      p_out[C_DT_BIT]   = i_usart_dt_out;
   end

   assign addr_ok     = i_hsel & i_htrans[1] & i_hready;
   assign ridx        = reg_index(i_haddr);
   assign rd_req      = addr_ok & ~i_hwrite;
   assign wr_d        = wr_pend_r & (wr_idx_r == GPIO_D_DATA_IDX);
   assign ext_wr_go   = (st_r == ST_IDLE) & mode_r & ~cs_n & ~wr_n;     // [RQ17] [RQ18]
   assign ext_rd_go   = (st_r == ST_IDLE) & mode_r & ~cs_n & wr_n & ~rd_n; // [RQ16] [RQ18]
   assign ext_wr_done = (st_r == ST_DONE) & (cnt_r == '0);

   always_comb begin
      c_lat_nxt   = c_lat_r;
      d_lat_nxt   = d_lat_r;
      e_lat_nxt   = e_lat_r;
      c_dir_nxt   = c_dir_r;
      d_dir_nxt   = d_dir_r;
      e_dir_nxt   = e_dir_r;
      mode_nxt    = mode_r;
      input_overflow_flag_nxt    = input_overflow_flag_r;
      ibf_nxt     = ibf_r;
      obf_nxt     = obf_r;
      in_lat_nxt  = in_lat_r;
      st_nxt      = st_r;
      cnt_nxt     = cnt_r;
      wr_pend_nxt = addr_ok & i_hwrite;
      wr_idx_nxt  = addr_ok ? ridx : wr_idx_r;
      hrdata_nxt  = '0;
      // register writes land in the data phase
      if (wr_pend_r) begin
         case (wr_idx_r)
            GPIO_C_DATA_IDX:      c_lat_nxt = i_hwdata[7:0];            // [RQ21]
            GPIO_D_DATA_IDX:      d_lat_nxt = i_hwdata[7:0];            // [RQ21]
            GPIO_E_DATA_IDX:      e_lat_nxt = i_hwdata[2:0];            // [RQ21]
            GPIO_C_DIRECTION_IDX: c_dir_nxt = i_hwdata[7:0];            // [RQ1]
            GPIO_D_DIRECTION_IDX: d_dir_nxt = i_hwdata[7:0];            // [RQ8]
            GPIO_E_DIR_CTRL_IDX: begin
               e_dir_nxt = i_hwdata[2:0];                               // [RQ10] [RQ15]
               mode_nxt  = i_hwdata[MODE_BIT];                          // [RQ9]
               input_overflow_flag_nxt  = i_hwdata[INPUT_OVERFLOW_FLAG_BIT];                          // [RQ14]
            end
            default: ;
         endcase
      end
      // read data is captured at the address phase edge
      if (rd_req) begin
         case (ridx)
            GPIO_C_DATA_IDX:      hrdata_nxt[7:0] = c_lvl;              // [RQ21]
            GPIO_D_DATA_IDX:      hrdata_nxt[7:0] = mode_r ? in_lat_r : d_lvl;
            GPIO_E_DATA_IDX:      hrdata_nxt[2:0] = e_lvl;              // [RQ19]
            GPIO_C_DIRECTION_IDX: hrdata_nxt[7:0] = c_dir_r;
            GPIO_D_DIRECTION_IDX: hrdata_nxt[7:0] = d_dir_r;
            GPIO_E_DIR_CTRL_IDX:
               hrdata_nxt[7:0] = {ibf_r, obf_r, input_overflow_flag_r, mode_r, 1'b0, e_dir_r}; // [RQ12] [RQ13] [RQ19]
            default: ;
         endcase
         if (ridx == GPIO_D_DATA_IDX && mode_r) begin
            ibf_nxt = 1'b0;                                             // [RQ22]
         end
      end
      if (wr_d && mode_r) begin
         obf_nxt = 1'b1;                                                // [RQ24]
      end
      // slave bus sequencer
      case (st_r)
         ST_IDLE: begin
            if (ext_wr_go) begin
               st_nxt = ST_WR;
               if (ibf_r) begin
                  input_overflow_flag_nxt = 1'b1;                                      // [RQ14]
               end
            end else if (ext_rd_go) begin
               st_nxt  = ST_RD;
               obf_nxt = 1'b0;                                          // [RQ24] [RQ13]
            end
         end
         ST_WR: begin
            if (cs_n || wr_n) begin
               st_nxt  = ST_DONE;
               cnt_nxt = PSP_DONE_LAST;
            end else begin
               // latch only while the strobe is low: data and strobe share the filter delay
               in_lat_nxt = d_lvl;                                      // [RQ17]
            end
         end
         ST_RD: begin
            if (cs_n || rd_n) begin
               st_nxt = ST_IDLE;
            end
         end
         ST_DONE: begin
            if (cnt_r == '0) begin
               st_nxt = ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - 2'h1;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      // a set in the same cycle as the processor read wins
      if (ext_wr_done) begin
         ibf_nxt = 1'b1;                                                // [RQ22]
      end
      if (!mode_nxt) begin
         ibf_nxt = 1'b0;                                                // [RQ23]
         obf_nxt = 1'b0;                                                // [RQ23]
         st_nxt  = ST_IDLE;
      end
      // pin drivers
      for (int i = 0; i < 8; i++) begin
         c_oe_nxt[i]  = p_sel[i] ? p_oe[i] : ~c_dir_nxt[i];             // [RQ2] [RQ4] [RQ20]
         c_out_nxt[i] = p_sel[i] ? p_out[i] : c_lat_nxt[i];             // [RQ2]
      end
      d_out_nxt = d_lat_nxt;
      if (mode_nxt) begin
         d_oe_nxt = (st_nxt == ST_RD) ? 8'hff : 8'h00;                  // [RQ9] [RQ16]
         e_oe_nxt = 3'h0;                                               // [RQ11]
      end else begin
         d_oe_nxt = ~d_dir_nxt;                                         // [RQ20]
         e_oe_nxt = ~e_dir_nxt;                                         // [RQ15] [RQ20]
      end
      e_out_nxt = e_lat_nxt;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         c_lat_r     <= LATCH_RST;
         d_lat_r     <= LATCH_RST;
         e_lat_r     <= '0;
         c_dir_r     <= C_DIR_RST;
         d_dir_r     <= D_DIR_RST;
         e_dir_r     <= E_DIR_RST;
         mode_r      <= 1'b0;
         input_overflow_flag_r      <= 1'b0;
         ibf_r       <= 1'b0;
         obf_r       <= 1'b0;
         in_lat_r    <= LATCH_RST;
         st_r        <= ST_IDLE;
         cnt_r       <= '0;
         wr_pend_r   <= 1'b0;
         wr_idx_r    <= '0;
         o_hrdata    <= '0;
         o_hreadyout <= 1'b0;
         o_hresp     <= 1'b0;
         o_c_out     <= LATCH_RST;
         o_c_oe      <= '0;
         o_c_level   <= '0;
         o_d_out     <= LATCH_RST;
         o_d_oe      <= '0;
         o_e_out     <= '0;
         o_e_oe      <= '0;
      end else begin
         c_lat_r     <= c_lat_nxt;
         d_lat_r     <= d_lat_nxt;
         e_lat_r     <= e_lat_nxt;
         c_dir_r     <= c_dir_nxt;
         d_dir_r     <= d_dir_nxt;
         e_dir_r     <= e_dir_nxt;
         mode_r      <= mode_nxt;
         input_overflow_flag_r      <= input_overflow_flag_nxt;
         ibf_r       <= ibf_nxt;
         obf_r       <= obf_nxt;
         in_lat_r    <= in_lat_nxt;
         st_r        <= st_nxt;
         cnt_r       <= cnt_nxt;
         wr_pend_r   <= wr_pend_nxt;
         wr_idx_r    <= wr_idx_nxt;
         o_hrdata    <= hrdata_nxt;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         o_c_out     <= c_out_nxt;
         o_c_oe      <= c_oe_nxt;
         o_c_level   <= pins_nxt[7:0];
         o_d_out     <= d_out_nxt;
         o_d_oe      <= d_oe_nxt;
         o_e_out     <= e_out_nxt;
         o_e_oe      <= e_oe_nxt;
      end
   end

   // checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);

   sdo_override_a: assert property (i_ssp_sel |=> o_c_oe[C_SDO_BIT]) // [RQ5]
      else $error("serial data out pin not driven");
   plain_dir_a: assert property (!i_ccp1_sel && !wr_pend_r |=>   // [RQ1]
      o_c_oe[C_CCP1_BIT] == !$past(c_dir_r[C_CCP1_BIT]))
      else $error("first port pin ignores direction bit");
   sel_gate_oe_a: assert property (!i_ccp1_sel && i_ccp1_oe && c_dir_r[C_CCP1_BIT] // [RQ4]
      && !wr_pend_r |=> !o_c_oe[C_CCP1_BIT])
      else $error("unselected peripheral drove pin");
   ccp2_drive_a: assert property (i_ccp2_sel && i_ccp2_oe |=>   // [RQ7]
      o_c_oe[C_CCP2_BIT] && o_c_out[C_CCP2_BIT] == $past(i_ccp2_out))
      else $error("second capture unit not routed");
   flags_clear_a: assert property (!mode_r |-> !ibf_r && !obf_r) // [RQ23]
      else $error("full flag set outside slave mode");
   strobe_input_a: assert property (mode_r |-> o_e_oe == 3'h0)   // [RQ11]
      else $error("strobe pin driven in slave mode");
   ibf_timing_a: assert property (st_r == ST_WR && (cs_n || wr_n) // [RQ22]
      && mode_r && !ibf_r |-> ##2 (!ibf_r || !mode_r) ##1 (ibf_r || !mode_r))
      else $error("input full not set on time");
   ibf_clear_a: assert property (rd_req && ridx == GPIO_D_DATA_IDX && mode_r // [RQ22]
      && !ext_wr_done |=> !ibf_r)
      else $error("input full not cleared by read");
   ibf_hold_a: assert property (ibf_r && mode_nxt // [RQ22]
      && !(rd_req && ridx == GPIO_D_DATA_IDX) |=> ibf_r)
      else $error("input full lost without a read");
   psp_float_a: assert property (mode_r && st_r != ST_RD |-> o_d_oe == 8'h00) // [RQ9]
      else $error("slave data bus driven outside a read");
   obf_set_a: assert property (wr_d && mode_r && !ext_rd_go |=> obf_r) // [RQ24]
      else $error("output full not set by write");
   ext_read_a: assert property (ext_rd_go |=> !obf_r && o_d_oe == 8'hff) // [RQ16]
      else $error("external read not served");
   overflow_a: assert property (ext_wr_go && ibf_r |=> input_overflow_flag_r)    // [RQ14]
      else $error("overflow not flagged");
   zero_bits_a: assert property (rd_req && ridx == GPIO_E_DATA_IDX |=> // [RQ19]
      o_hrdata[31:3] == '0)
      else $error("unimplemented bits not zero");

   ext_write_c: cover property (ext_wr_go ##[1:40] ext_wr_done);
   ext_read_c:  cover property (ext_rd_go ##[1:40] st_r == ST_IDLE);
   overflow_c:  cover property (ext_wr_go && ibf_r);
   override_c:  cover property (i_usart_sel && i_usart_tx_oe);
endmodule : three_port_io

// >>> testbench/psp_master_model.sv
// external 8-bit bus master on the slave data and strobe pins
`timescale 1ns/1ns
module psp_master_model (
   input  wire logic       i_ref_clk, // core clock
   input  wire logic [7:0] i_d_pin,   // resolved data pins
   output logic      [7:0] o_d_drv,   // data this master puts on the pins
   output logic      [2:0] o_e_drv    // {cs_n, wr_n, rd_n}
);
   initial begin
      o_d_drv = 8'h00;
      o_e_drv = 3'h7;
   end

   // wr 1 writes dat into the device, wr 0 reads into got
   task automatic bus_cycle(input logic wr, input logic cs_n, input logic [7:0] dat,
                            output logic [7:0] got);
      @(posedge i_ref_clk);
      o_d_drv <= dat;
      o_e_drv <= {cs_n, ~wr, wr};
      repeat (7) @(posedge i_ref_clk);
      #1 got = i_d_pin;
      @(posedge i_ref_clk);
      o_e_drv <= 3'h7;
      // released bus must not keep showing the byte just sent
      o_d_drv <= ~dat;
      repeat (10) @(posedge i_ref_clk);
   endtask : bus_cycle
endmodule : psp_master_model

// >>> testbench/three_port_io_tb.sv
// self-checking bench for the three-port block
`timescale 1ns/1ns
module three_port_io_tb;
   import gpio3_pkg::*;
   logic        clk, rst, hsel, hwrite, hready, hresp;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [7:0]  c_ext, c_out, c_oe, d_out, d_oe, d_drv, g, lvl;
   logic [2:0]  e_out, e_oe, e_drv;
   logic [16:0] per;
   int          bad_count, comparisons, cyc;

   three_port_io dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .i_c_pin((c_oe & c_out) | (~c_oe & c_ext)), .o_c_out(c_out), .o_c_oe(c_oe),
      .o_c_level(lvl), .i_d_pin((d_oe & d_out) | (~d_oe & d_drv)), .o_d_out(d_out),
      .o_d_oe(d_oe), .i_e_pin((e_oe & e_out) | (~e_oe & e_drv)), .o_e_out(e_out),
      .o_e_oe(e_oe), .i_ccp1_sel(per[0]), .i_ccp1_oe(per[1]), .i_ccp1_out(per[2]),
      .i_ccp2_sel(per[3]), .i_ccp2_oe(per[4]), .i_ccp2_out(per[5]), .i_ssp_sel(per[6]),
      .i_ssp_sck_oe(per[7]), .i_ssp_sck_out(per[8]), .i_ssp_sda_oe(per[9]),
      .i_ssp_sda_out(per[10]), .i_ssp_sdo_out(per[11]), .i_usart_sel(per[12]),
      .i_usart_tx_oe(per[13]), .i_usart_tx_out(per[14]), .i_usart_dt_oe(per[15]),
      .i_usart_dt_out(per[16]));

   psp_master_model pm (.i_ref_clk(clk), .i_d_pin((d_oe & d_out) | (~d_oe & d_drv)),
      .o_d_drv(d_drv), .o_e_drv(e_drv));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic final_report();
      if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ_BIT;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      r = hrdata;
   endtask : ahb

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      ahb(1'b0, idx, 32'h0);
      chk(r, exp);
   endtask : rdchk

   task automatic t_reset();
      rdchk(GPIO_C_DIRECTION_IDX, 32'h0000_00ff);
      rdchk(GPIO_D_DIRECTION_IDX, 32'h0000_00ff);
      rdchk(GPIO_E_DIR_CTRL_IDX, 32'h0000_0007);
      rdchk(GPIO_E_DATA_IDX, 32'h0000_0007);
      chk(32'({hresp, c_oe, d_oe, e_oe}), 32'h0);
      chk(32'(lvl), 32'h0000_003c);
   endtask : t_reset

   task automatic t_port_c();
      ahb(1'b1, GPIO_C_DIRECTION_IDX, 32'h0000_000f); // plain writes only
      ahb(1'b1, GPIO_C_DATA_IDX, 32'h0000_00a5);
      repeat (5) @(posedge clk);
      chk(32'(c_oe), 32'h0000_00f0);
      chk(32'(c_out & c_oe), 32'h0000_00a0);
      rdchk(GPIO_C_DATA_IDX, 32'h0000_00ac);
      // ccp1 drives 1, ccp2 unselected, sck drives 1, sda input, sdo 0, tx 0, dt input
      per <= 17'h0_031c7;
      repeat (5) @(posedge clk);
      chk(32'(c_oe), 32'h0000_006c);
      chk(32'(c_out & c_oe), 32'h0000_000c);
      per <= 17'h0_003a;
      repeat (5) @(posedge clk);
      chk(32'(c_oe), 32'h0000_00f2);
      chk(32'(c_out & c_oe), 32'h0000_00a2);
   endtask : t_port_c

   task automatic t_port_d_e();
      // driven strobe pins sit at idle high, so no false access once mode is on
      ahb(1'b1, GPIO_E_DATA_IDX, 32'h0000_0007);
      ahb(1'b1, GPIO_D_DIRECTION_IDX, 32'h0000_003c);
      ahb(1'b1, GPIO_E_DIR_CTRL_IDX, 32'h0000_0002);
      repeat (2) @(posedge clk);
      chk(32'({d_oe, e_oe, e_out}), 32'h0000_30ef);
      ahb(1'b1, GPIO_E_DIR_CTRL_IDX, 32'h0000_0017); // strobes kept input
      repeat (2) @(posedge clk);
      chk(32'({d_oe, e_oe}), 32'h0);
   endtask : t_port_d_e

   task automatic t_slave();
      ahb(1'b1, GPIO_D_DATA_IDX, 32'h0000_005a);
      rdchk(GPIO_E_DIR_CTRL_IDX, 32'h0000_0057);
      pm.bus_cycle(1'b1, 1'b0, 8'h33, g);
      rdchk(GPIO_E_DIR_CTRL_IDX, 32'h0000_00d7);
      pm.bus_cycle(1'b1, 1'b0, 8'h44, g);
      rdchk(GPIO_E_DIR_CTRL_IDX, 32'h0000_00f7);
      rdchk(GPIO_D_DATA_IDX, 32'h0000_0044);
      rdchk(GPIO_E_DIR_CTRL_IDX, 32'h0000_0077);
      ahb(1'b1, GPIO_E_DIR_CTRL_IDX, 32'h0000_0017);
      pm.bus_cycle(1'b0, 1'b1, 8'h00, g);
      pm.bus_cycle(1'b1, 1'b1, 8'h66, g);
      rdchk(GPIO_E_DIR_CTRL_IDX, 32'h0000_0057);
      pm.bus_cycle(1'b0, 1'b0, 8'h00, g);
      chk(32'(g), 32'h0000_005a);
      rdchk(GPIO_E_DIR_CTRL_IDX, 32'h0000_0017);
      ahb(1'b1, GPIO_D_DATA_IDX, 32'h0000_0011);
      pm.bus_cycle(1'b1, 1'b0, 8'h22, g);
      ahb(1'b1, GPIO_E_DIR_CTRL_IDX, 32'h0000_0027);
      rdchk(GPIO_E_DIR_CTRL_IDX, 32'h0000_0027);
   endtask : t_slave

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      c_ext = 8'h3c;
      per = 17'h0;
      bad_count = 0;
      comparisons = 0;
      cyc = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      t_reset();
      t_port_c();
      t_port_d_e();
      t_slave();
      final_report();
   end
endmodule : three_port_io_tb
